// >>> pkg/fsp_pkg.sv
`default_nettype none
package fsp_pkg;
  // Control register field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_ERASE_BIT = 1;
  localparam int unsigned CTRL_WRITE_BIT = 2;
  localparam int unsigned CTRL_REEN_BIT = 4;
  localparam int unsigned CTRL_BUSY_BIT = 6;
  localparam int unsigned CTRL_IE_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Command codes, bits 6:0 only; bit 7 is the interrupt enable
  localparam logic [6:0] CMD_LOAD = 7'h01;
  localparam logic [6:0] CMD_ERASE = 7'h03;
  localparam logic [6:0] CMD_WRITE = 7'h05;
  localparam logic [6:0] CMD_MASK = 7'h7f;
  // Store-program instruction must land within this many cycles of the write
  localparam logic [2:0] ARM_WINDOW = 3'h4;
  localparam logic [2:0] ARM_ZERO = 3'h0;
  localparam logic [2:0] ARM_STEP = 3'h1;
  // Pointer fields
  localparam int unsigned Z_PAGE_TOP = 12;
  localparam int unsigned Z_PAGE_LOW = 6;
  localparam int unsigned Z_WORD_TOP = 5;
  localparam int unsigned Z_WORD_LOW = 1;
  localparam int unsigned PAGE_W = 7;
  localparam int unsigned WORD_W = 5;
  localparam int unsigned BUF_DEPTH = 32;
  localparam int unsigned DATA_W = 16;
  // Section boundaries, in pages
  localparam logic [6:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h60;
  localparam logic [6:0] BOOT_FIRST_PAGE = 7'h70;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [31:0] NONE_LOADED = 32'h0000_0000;
  localparam logic [31:0] ONE_HOT_LSB = 32'h0000_0001;
  localparam logic [6:0] PAGE_ZERO = 7'h00;
  // Sequencer states
  typedef enum logic [2:0] {
    FSP_IDLE = 3'b001,
    FSP_ARMED = 3'b010,
    FSP_BUSY = 3'b100
  } fsp_state_t;
endpackage
`default_nettype wire

// >>> logic/fsp_page_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module fsp_page_buffer (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [fsp_pkg::WORD_W-1:0] wr_addr,
  input wire logic [fsp_pkg::DATA_W-1:0] wr_data,
  // Drain side
  input wire logic [fsp_pkg::WORD_W-1:0] rd_addr,
  output logic [fsp_pkg::DATA_W-1:0] rd_data,
  output logic any_loaded
);
  logic [fsp_pkg::DATA_W-1:0] mem [fsp_pkg::BUF_DEPTH];
  logic [fsp_pkg::BUF_DEPTH-1:0] valid_reg, valid_next;
  logic [fsp_pkg::DATA_W-1:0] rd_reg, rd_next;
  logic [fsp_pkg::BUF_DEPTH-1:0] wr_hot;

  // Valid bits stand in for a wide clear; a word never loaded reads as erased
  always_comb begin
    wr_hot = fsp_pkg::ONE_HOT_LSB << wr_addr;
    valid_next = valid_reg;
    if (clear) begin
      valid_next = fsp_pkg::NONE_LOADED;
    end else if (wr_en) begin
      valid_next = valid_reg | wr_hot;
    end
    rd_next = valid_reg[rd_addr] ? mem[rd_addr] : fsp_pkg::ERASED_WORD;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      valid_reg <= fsp_pkg::NONE_LOADED;
      rd_reg <= fsp_pkg::ERASED_WORD;
    end else begin
      valid_reg <= valid_next;
      rd_reg <= rd_next;
    end
  end

  // A reloaded word is dropped: only the first load after a clear counts
  always_ff @(posedge clk) begin
    if (wr_en && !clear && !valid_reg[wr_addr]) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = rd_reg;
  assign any_loaded = |valid_reg;
endmodule // fsp_page_buffer
`default_nettype wire

// >>> logic/fsp_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Erase needs erase code then instruction within four
// - Erase ignores data, uses pointer page field only
// - Erase: other section readable, no-READ_WHILE_WRITE_SECTION erase halts core
// - Load code plus instruction stores data at word field
// - Buffer clears on page write, re-enable, reset
// - EEPROM write during loading discards the buffer
// - Write code plus instruction writes page field page
// - Page write: no-READ_WHILE_WRITE_SECTION target halts core throughout
// - Enabled interrupt holds while enable bit clear
// - Busy flag and read block during READ_WHILE_WRITE_SECTION programming
// - Busy flag holds until re-enable bit written
// - Pointer bits 15:13 and bit 0 ignored
// - Programmed boot lock rejects boot section writes
module fsp_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Core side
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic store_program_instruction,
  input wire logic [15:0] z_ptr,
  input wire logic [fsp_pkg::DATA_W-1:0] write_data_pair,
  input wire logic eeprom_wr,
  input wire logic boot_lock_programmed,
  output logic [7:0] self_prog_control_reg,
  output logic section_busy_flag,
  output logic rww_read_block,
  output logic cpu_halt,
  output logic spm_irq,
  output logic cmd_rejected,
  // Flash array side
  output logic flash_erase_req,
  output logic flash_write_req,
  output logic [fsp_pkg::PAGE_W-1:0] flash_page,
  input wire logic flash_done,
  input wire logic [fsp_pkg::WORD_W-1:0] flash_buf_addr,
  output logic [fsp_pkg::DATA_W-1:0] flash_buf_data
);
  fsp_pkg::fsp_state_t state_reg, state_next;
  logic [6:0] cmd_reg, cmd_next;
  logic ie_reg, ie_next;
  logic en_reg, en_next;
  logic busy_reg, busy_next;
  logic halt_reg, halt_next;
  logic [2:0] win_reg, win_next;
  logic [fsp_pkg::PAGE_W-1:0] page_reg, page_next;
  logic erase_req_reg, erase_req_next;
  logic write_req_reg, write_req_next;
  logic op_write_reg, op_write_next;
  logic rej_reg, rej_next;
  logic buf_clear, buf_wr, buf_any;
  logic [fsp_pkg::PAGE_W-1:0] z_page;
  logic [fsp_pkg::WORD_W-1:0] z_word;

  // Section decode on page numbers
  function automatic logic in_no_read_while_write_section(input logic [fsp_pkg::PAGE_W-1:0] page);
    in_no_read_while_write_section = (page >= fsp_pkg::NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
  endfunction

  function automatic logic in_boot(input logic [fsp_pkg::PAGE_W-1:0] page);
    in_boot = (page >= fsp_pkg::BOOT_FIRST_PAGE);
  endfunction

  // Pointer split; bits 15:13 and bit 0 never reach the logic
  assign z_page = z_ptr[fsp_pkg::Z_PAGE_TOP:fsp_pkg::Z_PAGE_LOW];
  assign z_word = z_ptr[fsp_pkg::Z_WORD_TOP:fsp_pkg::Z_WORD_LOW];

  // Command sequencing
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    ie_next = ie_reg;
    en_next = en_reg;
    busy_next = busy_reg;
    halt_next = halt_reg;
    win_next = win_reg;
    page_next = page_reg;
    erase_req_next = 1'b0;
    write_req_next = 1'b0;
    op_write_next = op_write_reg;
    rej_next = 1'b0;
    buf_clear = 1'b0;
    buf_wr = 1'b0;
    unique case (state_reg)
      fsp_pkg::FSP_IDLE: begin
        if (ctrl_wr) begin
          ie_next = ctrl_wdata[fsp_pkg::CTRL_IE_BIT];
          if (ctrl_wdata[fsp_pkg::CTRL_REEN_BIT]) begin
            // Re-enable frees the section and flushes the buffer
            busy_next = 1'b0;
            buf_clear = 1'b1;
          end else if (ctrl_wdata[fsp_pkg::CTRL_EN_BIT]) begin
            cmd_next = ctrl_wdata[6:0] & fsp_pkg::CMD_MASK;
            en_next = 1'b1;
            win_next = fsp_pkg::ARM_WINDOW;
            state_next = fsp_pkg::FSP_ARMED;
          end
        end
      end
      fsp_pkg::FSP_ARMED: begin
        if (store_program_instruction) begin
          en_next = 1'b0;
          state_next = fsp_pkg::FSP_IDLE;
          unique case (cmd_reg)
            fsp_pkg::CMD_LOAD: begin
              buf_wr = 1'b1;
              en_next = 1'b0;
            end
            fsp_pkg::CMD_ERASE, fsp_pkg::CMD_WRITE: begin
              if (boot_lock_programmed && in_boot(z_page)) begin
                rej_next = 1'b1;
              end else begin
                // Data pair is not looked at for either operation
                page_next = z_page;
                en_next = 1'b1;
                op_write_next = (cmd_reg == fsp_pkg::CMD_WRITE);
                erase_req_next = (cmd_reg == fsp_pkg::CMD_ERASE);
                write_req_next = (cmd_reg == fsp_pkg::CMD_WRITE);
                halt_next = in_no_read_while_write_section(z_page);
                busy_next = busy_reg | !in_no_read_while_write_section(z_page);
                state_next = fsp_pkg::FSP_BUSY;
              end
            end
            default: begin
              rej_next = 1'b1;
            end
          endcase
        end else if (win_reg == fsp_pkg::ARM_STEP) begin
          // The fourth edge after the write is the last one that may carry the strobe
          en_next = 1'b0;
          state_next = fsp_pkg::FSP_IDLE;
        end else begin
          win_next = win_reg - fsp_pkg::ARM_STEP;
        end
      end
      fsp_pkg::FSP_BUSY: begin
        if (flash_done) begin
          en_next = 1'b0;
          halt_next = 1'b0;
          buf_clear = op_write_reg;
          state_next = fsp_pkg::FSP_IDLE;
        end
      end
      default: begin
        state_next = fsp_pkg::FSP_IDLE;
        en_next = 1'b0;
        halt_next = 1'b0;
      end
    endcase
    // EEPROM activity while words are loaded loses the loaded page
    if (eeprom_wr && buf_any) begin
      buf_clear = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= fsp_pkg::FSP_IDLE;
      cmd_reg <= fsp_pkg::CTRL_RESET[6:0];
      ie_reg <= 1'b0;
      en_reg <= 1'b0;
      busy_reg <= 1'b0;
      halt_reg <= 1'b0;
      win_reg <= fsp_pkg::ARM_ZERO;
      page_reg <= fsp_pkg::PAGE_ZERO;
      erase_req_reg <= 1'b0;
      write_req_reg <= 1'b0;
      op_write_reg <= 1'b0;
      rej_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      ie_reg <= ie_next;
      en_reg <= en_next;
      busy_reg <= busy_next;
      halt_reg <= halt_next;
      win_reg <= win_next;
      page_reg <= page_next;
      erase_req_reg <= erase_req_next;
      write_req_reg <= write_req_next;
      op_write_reg <= op_write_next;
      rej_reg <= rej_next;
    end
  end

  // Temporary page buffer; reset clears it inside
  fsp_page_buffer u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(buf_clear),
    .wr_en(buf_wr),
    .wr_addr(z_word),
    .wr_data(write_data_pair),
    .rd_addr(flash_buf_addr),
    .rd_data(flash_buf_data),
    .any_loaded(buf_any)
  );

  // Status and control read-back
  always_comb begin
    self_prog_control_reg = fsp_pkg::CTRL_RESET;
    self_prog_control_reg[fsp_pkg::CTRL_IE_BIT] = ie_reg;
    self_prog_control_reg[fsp_pkg::CTRL_BUSY_BIT] = busy_reg;
    self_prog_control_reg[fsp_pkg::CTRL_WRITE_BIT] = en_reg & cmd_reg[fsp_pkg::CTRL_WRITE_BIT];
    self_prog_control_reg[fsp_pkg::CTRL_ERASE_BIT] = en_reg & cmd_reg[fsp_pkg::CTRL_ERASE_BIT];
    self_prog_control_reg[fsp_pkg::CTRL_EN_BIT] = en_reg;
  end

  assign section_busy_flag = busy_reg;
  // Every erase or write blocks the shared section; a halting one shows it through the halt
  assign rww_read_block = busy_reg | halt_reg;
  assign cpu_halt = halt_reg;
  assign spm_irq = ie_reg & !en_reg;
  assign cmd_rejected = rej_reg;
  assign flash_erase_req = erase_req_reg;
  assign flash_write_req = write_req_reg;
  assign flash_page = page_reg;
endmodule // fsp_sequencer
`default_nettype wire

// >>> tb/fsp_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// Flash array stand-in: done pulses lat+2 cycles after a request
module fsp_flash_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sequencer side
  input wire logic flash_erase_req,
  input wire logic flash_write_req,
  input wire logic [3:0] lat,
  output logic flash_done
);
  logic [3:0] cnt_reg, cnt_next;
  logic run_reg, run_next, done_next;
  // Never answers without a request, so a stray done is impossible
  always_comb begin
    cnt_next = cnt_reg - 4'h1;
    run_next = run_reg && cnt_reg != 4'h0;
    done_next = run_reg && cnt_reg == 4'h0;
    if (flash_erase_req || flash_write_req) begin
      cnt_next = lat;
      run_next = 1'b1;
    end
  end
  // Registers only
  always_ff @(posedge clk) begin
    cnt_reg <= sys_rst ? 4'h0 : cnt_next;
    run_reg <= !sys_rst && run_next;
    flash_done <= !sys_rst && done_next;
  end
endmodule // fsp_flash_model
`default_nettype wire

// >>> tb/fsp_sequencer_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module fsp_sequencer_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Core side
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic store_program_instruction,
  input wire logic [15:0] z_ptr,
  input wire logic boot_lock_programmed,
  input wire logic [7:0] self_prog_control_reg,
  input wire logic section_busy_flag,
  input wire logic rww_read_block,
  input wire logic cpu_halt,
  input wire logic spm_irq,
  input wire logic cmd_rejected,
  // Flash side
  input wire logic flash_erase_req,
  input wire logic flash_write_req,
  input wire logic [6:0] flash_page,
  input wire logic flash_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Enable low means idle, the only state that takes writes
  wire logic en = self_prog_control_reg[0];
  wire logic stb = store_program_instruction;
  wire logic req = flash_erase_req | flash_write_req;
  wire logic op = |self_prog_control_reg[2:1];
  sequence arm_s;
    ctrl_wr && ctrl_wdata[0] && !ctrl_wdata[4] && !en;
  endsequence
  sequence miss_s;
    arm_s ##1 !stb [*4];
  endsequence
  arm_sets_a: assert property (arm_s |=> en) else $error("enable not set");
  window_miss_a: assert property (miss_s |=> !en) else $error("stale arm");
  req_cause_a: assert property (req |-> $past(stb) && flash_page == $past(z_ptr[12:6]))
    else $error("bad request");
  halt_page_a: assert property (req |-> cpu_halt == (flash_page >= fsp_pkg::NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
    && (cpu_halt || section_busy_flag)) else $error("bad halt");
  busy_block_a: assert property (rww_read_block == (section_busy_flag || cpu_halt)) else $error("block");
  busy_holds_a: assert property (section_busy_flag && !ctrl_wr |=> section_busy_flag)
    else $error("busy dropped");
  reen_clear_a: assert property (ctrl_wr && ctrl_wdata[4] && !en |=> !section_busy_flag)
    else $error("busy kept");
  irq_level_a: assert property (spm_irq == (self_prog_control_reg[7] && !en)) else $error("irq");
  done_ends_a: assert property (flash_done |=> !en && !cpu_halt) else $error("op open");
  load_ends_a: assert property (stb && en && !op |=> !en) else $error("load open");
  boot_guard_a: assert property (stb && en && op && boot_lock_programmed
    && z_ptr[12:6] >= fsp_pkg::BOOT_FIRST_PAGE |=> cmd_rejected && !req) else $error("boot");
endmodule // fsp_sequencer_assertions
bind fsp_sequencer fsp_sequencer_assertions u_chk (.clk, .sys_rst, .ctrl_wr, .ctrl_wdata,
  .store_program_instruction, .z_ptr, .boot_lock_programmed, .self_prog_control_reg,
  .section_busy_flag, .rww_read_block, .cpu_halt, .spm_irq, .cmd_rejected,
  .flash_erase_req, .flash_write_req, .flash_page, .flash_done);
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // Stimulus, held at legal idle values from time zero
  logic clk = 1'b0, sys_rst = 1'b1, ctrl_wr = 1'b0, store_program_instruction = 1'b0;
  logic eeprom_wr = 1'b0, boot_lock_programmed = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00, self_prog_control_reg;
  logic [15:0] z_ptr = 16'h0000, write_data_pair = 16'h0000, flash_buf_data;
  logic [4:0] flash_buf_addr = 5'h00;
  logic [3:0] lat = 4'h1;
  logic [6:0] flash_page;
  logic section_busy_flag, rww_read_block, cpu_halt, spm_irq, cmd_rejected;
  logic flash_erase_req, flash_write_req, flash_done;
  localparam logic [15:0] BLANK = fsp_pkg::ERASED_WORD;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  // 50 ns period
  always #25 clk = ~clk;
  fsp_sequencer dut (.clk, .sys_rst, .ctrl_wr, .ctrl_wdata, .store_program_instruction, .z_ptr,
    .write_data_pair, .eeprom_wr, .boot_lock_programmed, .self_prog_control_reg, .section_busy_flag,
    .rww_read_block, .cpu_halt, .spm_irq, .cmd_rejected, .flash_erase_req, .flash_write_req,
    .flash_page, .flash_done, .flash_buf_addr, .flash_buf_data);
  fsp_flash_model far_end (.clk, .sys_rst, .flash_erase_req, .flash_write_req, .lat, .flash_done);
  task automatic wrap_up;
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // The run needs under a hundred cycles; this catches a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up;
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  // Control write, then a strobe on the g-th edge after it (0: none)
  task automatic op(input logic [7:0] c, input logic [15:0] z, d, input int g);
    ctrl_wr = 1'b1;
    ctrl_wdata = c;
    tick(1);
    ctrl_wr = 1'b0;
    if (g > 0) begin
      tick(g - 1);
      store_program_instruction = 1'b1;
      z_ptr = z;
      write_data_pair = d;
      tick(1);
      store_program_instruction = 1'b0;
    end
  endtask
  // Buffer data follows its address by one cycle
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    flash_buf_addr = a;
    tick(1);
    chk("buf", e, flash_buf_data);
  endtask
  task automatic wt;
    for (int i = 0; i < 40 && self_prog_control_reg[0] !== 1'b0; i++) tick(1);
  endtask
  // Loads at both window edges, reload, EEPROM loss, missed window
  task automatic t_load;
    op(8'h01, 16'he007, 16'h1234, 4);
    op(8'h01, 16'h0006, 16'h5678, 1);
    op(8'h01, 16'h000e, 16'hbeef, 2);
    rd(5'h03, 16'h1234);
    rd(5'h07, 16'hbeef);
    eeprom_wr = 1'b1;
    tick(1);
    eeprom_wr = 1'b0;
    rd(5'h03, BLANK);
    op(8'h01, 16'h0000, 16'h0000, 0);
    tick(3);
    chk("en", 1'b1, self_prog_control_reg[0]);
    tick(1);
    chk("en", 1'b0, self_prog_control_reg[0]);
    op(8'h00, 16'h0012, 16'h2222, 1);
    rd(5'h09, BLANK);
    op(8'h01, 16'h0010, 16'h7777, 5);
    rd(5'h08, BLANK);
  endtask
  // Erase in the shared section with a slow flash, busy until re-enable
  task automatic t_erase;
    lat = 4'h6;
    op(8'h83, 16'he17f, 16'h3333, 1);
    chk("erase", 1'b1, flash_erase_req);
    chk("page", 16'h0005, flash_page);
    chk("block", 1'b1, rww_read_block);
    chk("ctrl", 16'h00c3, self_prog_control_reg);
    chk("irq", 1'b0, spm_irq);
    wt;
    chk("busy", 1'b1, section_busy_flag);
    chk("irq", 1'b1, spm_irq);
    op(8'h11, 16'h0000, 16'h0000, 0);
    chk("busy", 1'b0, section_busy_flag);
    chk("ctrl", 16'h0000, self_prog_control_reg);
    tick(1);
  endtask
  // Write into the halting section, boot lock, buffer clears
  task automatic t_write;
    lat = 4'h1;
    op(8'h01, 16'h0004, 16'ha5a5, 4);
    op(8'h05, 16'h1940, 16'h0000, 2);
    chk("write", 1'b1, flash_write_req);
    chk("halt", 1'b1, cpu_halt);
    chk("block", 1'b1, rww_read_block);
    chk("page", 16'h0065, flash_page);
    wt;
    chk("halt", 1'b0, cpu_halt);
    rd(5'h02, BLANK);
    boot_lock_programmed = 1'b1;
    op(8'h05, 16'h1c80, 16'h0000, 1);
    chk("reject", 1'b1, cmd_rejected);
    boot_lock_programmed = 1'b0;
    tick(1);
    op(8'h03, 16'h1c80, 16'h0000, 3);
    chk("halt", 1'b1, cpu_halt);
    wt;
    op(8'h01, 16'h0002, 16'h1111, 1);
    op(8'h10, 16'h0000, 16'h0000, 0);
    rd(5'h01, BLANK);
    op(8'h01, 16'h0002, 16'h1111, 1);
    sys_rst = 1'b1;
    tick(1);
    sys_rst = 1'b0;
    rd(5'h01, BLANK);
  endtask
  initial begin
    tick(3);
    sys_rst = 1'b0;
    t_load;
    t_erase;
    t_write;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
